// ---- hdl/mbs_crc16_byte.sv ----
// One-byte update of the reflected CRC-16 check sum.
`timescale 1ns/100ps
module mbs_crc16_byte (
  // Running value and new byte
  input  wire logic [15:0] crc_in,
  input  wire logic [7:0]  data_in,
  // Updated value
  output logic      [15:0] crc_out
);
  always_comb begin
    crc_out = crc_in ^ {8'h00, data_in};
    for (int i = 0; i < 8; i++) begin
      if (crc_out[0]) begin
        crc_out = (crc_out >> 1) ^ mbs_pkg::CRC_POLY;
      end else begin
        crc_out = crc_out >> 1;
      end
    end
  end
endmodule // mbs_crc16_byte

// ---- hdl/mbs_pkg.sv ----
// Constants, codes and types shared by the serial bus slave telegram unit.
package mbs_pkg;

  // ==========================================================================
  // Clock and line rates
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CLK_HZ        = 1_000_000_000 / CLK_PERIOD_NS;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned BAUD_9600     = 9600;
  localparam int unsigned BAUD_19200    = 19200;
  localparam int unsigned BAUD_38400    = 38400;
  localparam logic [1:0]  BAUD_SEL_9600  = 2'h0;
  localparam logic [1:0]  BAUD_SEL_19200 = 2'h1;
  localparam logic [1:0]  BAUD_SEL_38400 = 2'h2;

  // ==========================================================================
  // Character framing and silence limits, in bit times
  localparam int unsigned CHAR_BITS    = 11;
  localparam logic [3:0]  LAST_BIT     = 4'(CHAR_BITS - 1);
  localparam logic [5:0]  GAP_T15_BITS = 6'((CHAR_BITS * 3 + 1) / 2);
  localparam logic [5:0]  GAP_T35_BITS = 6'((CHAR_BITS * 7 + 1) / 2);

  // ==========================================================================
  // Check sum
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;

  // ==========================================================================
  // Addressing, function codes and limits
  localparam logic [7:0]  ADDR_MIN     = 8'h01;
  localparam logic [7:0]  ADDR_MAX     = 8'hf7;
  localparam logic [7:0]  ADDR_DEFAULT = 8'h14;
  localparam logic [7:0]  FC_READ      = 8'h03;
  localparam logic [7:0]  FC_WRITE1    = 8'h06;
  localparam logic [7:0]  FC_WRITEN    = 8'h10;
  localparam logic [7:0]  FC_RDWR      = 8'h17;
  localparam logic [7:0]  EXC_FLAG     = 8'h80;
  localparam logic [7:0]  EXC_NONE     = 8'h00;
  localparam logic [7:0]  EXC_FUNC     = 8'h01;
  localparam logic [7:0]  EXC_VALUE    = 8'h03;
  localparam logic [15:0] MAX_RD       = 16'h007d;
  localparam logic [15:0] MAX_WR       = 16'h007b;
  localparam logic [15:0] MAX_RDWR_WR  = 16'h0079;
  localparam logic [15:0] ONE_REG      = 16'h0001;

  // ==========================================================================
  // Telegram byte positions and lengths
  localparam logic [7:0] P_ADDR   = 8'h00;
  localparam logic [7:0] P_FC     = 8'h01;
  localparam logic [7:0] P_W2     = 8'h02;
  localparam logic [7:0] P_W4     = 8'h04;
  localparam logic [7:0] P_W6     = 8'h06;
  localparam logic [7:0] P_W8     = 8'h08;
  localparam logic [7:0] P_BC10   = 8'h0a;
  localparam logic [7:0] WBASE_06 = 8'h04;
  localparam logic [7:0] WBASE_10 = 8'h07;
  localparam logic [7:0] WBASE_17 = 8'h0b;
  localparam logic [8:0] LEN_MIN     = 9'h004;
  localparam logic [8:0] LEN_FIXED   = 9'h008;
  localparam logic [8:0] LEN_WN_BASE = 9'h009;
  localparam logic [8:0] LEN_RW_BASE = 9'h00d;
  localparam logic [8:0] RD_HDR      = 9'h003;
  localparam logic [8:0] ECHO_BODY   = 9'h006;
  localparam logic [8:0] EXC_BODY    = 9'h003;
  localparam logic [8:0] RD_DATA0    = 9'h003;

  // ==========================================================================
  // Indication
  localparam logic [7:0] FLASH_MS = 8'hfa;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_CHECK = 3'h1,
    ST_WRITE = 3'h3,
    ST_PREP  = 3'h2,
    ST_FETCH = 3'h6,
    ST_SEND  = 3'h7,
    ST_WAIT  = 3'h5
  } mbs_state_e;

  typedef enum logic [1:0] {
    RESP_READ = 2'h0,
    RESP_ECHO = 2'h1,
    RESP_EXC  = 2'h2
  } mbs_resp_e;

endpackage

// ---- hdl/mbs_slave.sv ----
// Serial bus slave: receives, checks, executes and answers register telegrams.
`timescale 1ns/100ps
module mbs_slave #(
  parameter int unsigned BIT_CYC_9600  = mbs_pkg::CLK_HZ / mbs_pkg::BAUD_9600,
  parameter int unsigned BIT_CYC_19200 = mbs_pkg::CLK_HZ / mbs_pkg::BAUD_19200,
  parameter int unsigned BIT_CYC_38400 = mbs_pkg::CLK_HZ / mbs_pkg::BAUD_38400,
  parameter int unsigned MS_CYC        = mbs_pkg::CLK_HZ / mbs_pkg::MS_PER_S,
  parameter int unsigned BUF_DEPTH     = 256
) (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  // Line transceiver
  input  wire logic        rx_pin_in,
  output logic             tx_out,
  output logic             tx_en_out,
  // Settings
  input  wire logic [7:0]  slave_addr_in,
  input  wire logic [1:0]  baud_sel_in,
  input  wire logic [13:0] monitor_ms_in,
  input  wire logic        bus_active_in,
  // Register port
  output logic      [15:0] reg_addr_out,
  output logic      [15:0] reg_wdata_out,
  output logic             reg_wr_out,
  output logic             reg_rd_out,
  input  wire logic [15:0] reg_rdata_in,
  // Indication
  output logic             activity_led_out,
  output logic             fault_led_out,
  output logic             pump_stop_out
);
  // ==========================================================================
  // Line rate and own address
  logic [15:0] bit_cyc;
  logic [7:0]  my_addr;
  always_comb begin
    case (baud_sel_in)
      mbs_pkg::BAUD_SEL_9600:  bit_cyc = 16'(BIT_CYC_9600);
      mbs_pkg::BAUD_SEL_38400: bit_cyc = 16'(BIT_CYC_38400);
      default:                 bit_cyc = 16'(BIT_CYC_19200);
    endcase
  end
  // An out-of-range setting falls back to the default rather than going deaf.
  assign my_addr = (slave_addr_in >= mbs_pkg::ADDR_MIN && slave_addr_in <= mbs_pkg::ADDR_MAX)
                   ? slave_addr_in : mbs_pkg::ADDR_DEFAULT;

  mbs_pkg::mbs_state_e st_r;

  // ==========================================================================
  // Receiver
  logic       rx_meta_r, rx_sync_r;
  logic       rx_busy_r, rx_done_r, rx_err_r;
  logic [15:0] rx_cnt_r;
  logic [3:0] rx_bit_r;
  logic [8:0] rx_sh_r;
  logic [7:0] rx_byte_r;
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
    end else begin
      rx_meta_r <= rx_pin_in;
      rx_sync_r <= rx_meta_r;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rx_busy_r <= 1'b0;
      rx_done_r <= 1'b0;
      rx_err_r  <= 1'b0;
      rx_cnt_r  <= 16'h0000;
      rx_bit_r  <= 4'h0;
      rx_sh_r   <= 9'h000;
      rx_byte_r <= 8'h00;
    end else begin
      rx_done_r <= 1'b0;
      if (!rx_busy_r) begin
        // Half duplex: nothing is heard while a telegram is being handled.
        if (!rx_sync_r && st_r == mbs_pkg::ST_IDLE) begin
          rx_busy_r <= 1'b1;
          rx_cnt_r  <= bit_cyc >> 1;
          rx_bit_r  <= 4'h0;
        end
      end else if (rx_cnt_r != 16'h0000) begin
        rx_cnt_r <= rx_cnt_r - 16'h0001;
      end else begin
        rx_cnt_r <= bit_cyc - 16'h0001;
        rx_bit_r <= rx_bit_r + 4'h1;
        if (rx_bit_r == 4'h0) begin
          rx_busy_r <= ~rx_sync_r;
        end else if (rx_bit_r == mbs_pkg::LAST_BIT) begin
          rx_busy_r <= 1'b0;
          rx_done_r <= 1'b1;
          rx_byte_r <= rx_sh_r[7:0];
          rx_err_r  <= ~rx_sync_r | (^rx_sh_r);
        end else begin
          rx_sh_r <= {rx_sync_r, rx_sh_r[8:1]};
        end
      end
    end
  end

  // ==========================================================================
  // Silence timing, counted in bit times
  logic [15:0] idle_cyc_r;
  logic [5:0]  idle_bits_r;
  logic        fr_end;
  always_ff @(posedge core_clk_in) begin
    if (reset_in || rx_busy_r || !rx_sync_r || tx_en_out) begin
      idle_cyc_r  <= 16'h0000;
      idle_bits_r <= 6'h00;
    end else if (idle_cyc_r == bit_cyc - 16'h0001) begin
      idle_cyc_r <= 16'h0000;
      if (idle_bits_r != mbs_pkg::GAP_T35_BITS) begin
        idle_bits_r <= idle_bits_r + 6'h01;
      end
    end else begin
      idle_cyc_r <= idle_cyc_r + 16'h0001;
    end
  end
  assign fr_end = idle_cyc_r == bit_cyc - 16'h0001
                  && idle_bits_r == mbs_pkg::GAP_T35_BITS - 6'h01;

  // ==========================================================================
  // Frame collection and check sum
  logic [7:0]  buf_r [BUF_DEPTH];
  logic [8:0]  len_r;
  logic        fr_active_r, fr_bad_r, gap_r, link_err_r;
  logic [15:0] crc_r, crc_nxt, crc_seed;
  logic [7:0]  crc_data, tx_byte_r;
  logic [8:0]  body_r, tx_idx_r;
  logic        good_req;

  assign crc_seed = (rx_done_r && !fr_active_r) ? mbs_pkg::CRC_INIT : crc_r;
  assign crc_data = rx_done_r ? rx_byte_r : tx_byte_r;
  mbs_crc16_byte u_crc (
    .crc_in  (crc_seed),
    .data_in (crc_data),
    .crc_out (crc_nxt)
  );

  // Only a clean, complete frame for us opens an exchange; all else is dropped silently.
  assign good_req = fr_end && fr_active_r && !fr_bad_r && crc_r == 16'h0000
                    && len_r >= mbs_pkg::LEN_MIN
                    && buf_r[mbs_pkg::P_ADDR] == my_addr;

  always_ff @(posedge core_clk_in) begin
    if (rx_done_r && len_r < 9'(BUF_DEPTH)) begin
      buf_r[fr_active_r ? len_r[7:0] : 8'h00] <= rx_byte_r;
    end
  end

  // After reset the line is distrusted until a full silence has been seen.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      len_r       <= 9'h000;
      fr_active_r <= 1'b1;
      fr_bad_r    <= 1'b1;
      gap_r       <= 1'b0;
      link_err_r  <= 1'b0;
    end else if (rx_done_r) begin
      fr_active_r <= 1'b1;
      gap_r       <= 1'b0;
      if (!fr_active_r) begin
        len_r    <= 9'h001;
        fr_bad_r <= rx_err_r;
      end else begin
        len_r    <= (len_r == 9'(BUF_DEPTH)) ? len_r : len_r + 9'h001;
        fr_bad_r <= fr_bad_r | rx_err_r | gap_r | len_r == 9'(BUF_DEPTH);
      end
    end else begin
      if (fr_active_r && idle_bits_r >= mbs_pkg::GAP_T15_BITS) begin
        gap_r <= 1'b1;
      end
      if (fr_end && fr_active_r) begin
        fr_active_r <= 1'b0;
        if (len_r != 9'h000) begin
          link_err_r <= fr_bad_r | crc_r != 16'h0000;
        end
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      crc_r <= mbs_pkg::CRC_INIT;
    end else if (rx_done_r) begin
      crc_r <= crc_nxt;
    end else if (st_r == mbs_pkg::ST_CHECK) begin
      crc_r <= mbs_pkg::CRC_INIT;
    end else if (st_r == mbs_pkg::ST_SEND && tx_idx_r < body_r) begin
      crc_r <= crc_nxt;
    end
  end

  // ==========================================================================
  // Request decoding
  logic [7:0]  fc;
  logic [15:0] w2, w4, w6, w8;
  logic [7:0]  dec_exc, dec_wb;
  logic [15:0] dec_rc, dec_ws, dec_wc;
  mbs_pkg::mbs_resp_e dec_resp;

  function automatic logic in_rng(input logic [15:0] v, input logic [15:0] mx);
    in_rng = v != 16'h0000 && v <= mx;
  endfunction

  assign fc = buf_r[mbs_pkg::P_FC];
  assign w2 = {buf_r[mbs_pkg::P_W2], buf_r[mbs_pkg::P_W2 + 8'h01]};
  assign w4 = {buf_r[mbs_pkg::P_W4], buf_r[mbs_pkg::P_W4 + 8'h01]};
  assign w6 = {buf_r[mbs_pkg::P_W6], buf_r[mbs_pkg::P_W6 + 8'h01]};
  assign w8 = {buf_r[mbs_pkg::P_W8], buf_r[mbs_pkg::P_W8 + 8'h01]};

  always_comb begin
    dec_exc  = mbs_pkg::EXC_NONE;
    dec_rc   = 16'h0000;
    dec_ws   = w2;
    dec_wc   = 16'h0000;
    dec_wb   = mbs_pkg::WBASE_06;
    dec_resp = mbs_pkg::RESP_ECHO;
    case (fc)
      mbs_pkg::FC_READ: begin
        dec_rc   = w4;
        dec_resp = mbs_pkg::RESP_READ;
        if (len_r != mbs_pkg::LEN_FIXED || !in_rng(w4, mbs_pkg::MAX_RD)) begin
          dec_exc = mbs_pkg::EXC_VALUE;
        end
      end
      mbs_pkg::FC_WRITE1: begin
        dec_wc = mbs_pkg::ONE_REG;
        if (len_r != mbs_pkg::LEN_FIXED) begin
          dec_exc = mbs_pkg::EXC_VALUE;
        end
      end
      mbs_pkg::FC_WRITEN: begin
        dec_wc = w4;
        dec_wb = mbs_pkg::WBASE_10;
        if (!in_rng(w4, mbs_pkg::MAX_WR) || buf_r[mbs_pkg::P_W6] != {w4[6:0], 1'b0}
            || len_r != mbs_pkg::LEN_WN_BASE + {w4[7:0], 1'b0}) begin
          dec_exc = mbs_pkg::EXC_VALUE;
        end
      end
      mbs_pkg::FC_RDWR: begin
        dec_rc   = w4;
        dec_ws   = w6;
        dec_wc   = w8;
        dec_wb   = mbs_pkg::WBASE_17;
        dec_resp = mbs_pkg::RESP_READ;
        if (!in_rng(w4, mbs_pkg::MAX_RD) || !in_rng(w8, mbs_pkg::MAX_RDWR_WR)
            || buf_r[mbs_pkg::P_BC10] != {w8[6:0], 1'b0}
            || len_r != mbs_pkg::LEN_RW_BASE + {w8[7:0], 1'b0}) begin
          dec_exc = mbs_pkg::EXC_VALUE;
        end
      end
      default: dec_exc = mbs_pkg::EXC_FUNC;
    endcase
    if (dec_exc != mbs_pkg::EXC_NONE) begin
      dec_rc   = 16'h0000;
      dec_wc   = 16'h0000;
      dec_resp = mbs_pkg::RESP_EXC;
    end
  end

  // ==========================================================================
  // Sequencer: writes, then the answer byte by byte
  mbs_pkg::mbs_resp_e resp_r;
  logic [7:0]  exc_r, wb_r, wr_k_r;
  logic [15:0] rs_r, rc_r, ws_r, wc_r, word_r;
  logic [7:0]  tx_sel;
  logic [8:0]  rd_off;
  logic        need_fetch, tx_busy_r;

  assign rd_off     = tx_idx_r - mbs_pkg::RD_DATA0;
  assign need_fetch = resp_r == mbs_pkg::RESP_READ && tx_idx_r >= mbs_pkg::RD_DATA0
                      && tx_idx_r < body_r && !rd_off[0];

  always_comb begin
    if (tx_idx_r == body_r) begin
      tx_sel = crc_r[7:0];
    end else if (tx_idx_r == body_r + 9'h001) begin
      tx_sel = crc_r[15:8];
    end else if (tx_idx_r == 9'h000) begin
      tx_sel = buf_r[mbs_pkg::P_ADDR];
    end else if (tx_idx_r == 9'h001) begin
      tx_sel = (resp_r == mbs_pkg::RESP_EXC) ? (fc | mbs_pkg::EXC_FLAG) : fc;
    end else if (resp_r == mbs_pkg::RESP_EXC) begin
      tx_sel = exc_r;
    end else if (resp_r == mbs_pkg::RESP_ECHO) begin
      tx_sel = buf_r[tx_idx_r[7:0]];
    end else if (tx_idx_r == 9'h002) begin
      tx_sel = {rc_r[6:0], 1'b0};
    end else begin
      tx_sel = word_r[7:0];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      st_r      <= mbs_pkg::ST_IDLE;
      resp_r    <= mbs_pkg::RESP_EXC;
      exc_r     <= 8'h00;
      wb_r      <= 8'h00;
      wr_k_r    <= 8'h00;
      rs_r      <= 16'h0000;
      rc_r      <= 16'h0000;
      ws_r      <= 16'h0000;
      wc_r      <= 16'h0000;
      word_r    <= 16'h0000;
      body_r    <= 9'h000;
      tx_idx_r  <= 9'h000;
      tx_byte_r <= 8'h00;
    end else begin
      case (st_r)
        mbs_pkg::ST_IDLE: if (good_req) st_r <= mbs_pkg::ST_CHECK;
        mbs_pkg::ST_CHECK: begin
          resp_r   <= dec_resp;
          exc_r    <= dec_exc;
          rs_r     <= w2;
          rc_r     <= dec_rc;
          ws_r     <= dec_ws;
          wc_r     <= dec_wc;
          wb_r     <= dec_wb;
          wr_k_r   <= 8'h00;
          tx_idx_r <= 9'h000;
          case (dec_resp)
            mbs_pkg::RESP_READ: body_r <= mbs_pkg::RD_HDR + {dec_rc[7:0], 1'b0};
            mbs_pkg::RESP_ECHO: body_r <= mbs_pkg::ECHO_BODY;
            default:            body_r <= mbs_pkg::EXC_BODY;
          endcase
          st_r <= (dec_wc != 16'h0000) ? mbs_pkg::ST_WRITE : mbs_pkg::ST_PREP;
        end
        mbs_pkg::ST_WRITE: begin
          wr_k_r <= wr_k_r + 8'h01;
          if ({8'h00, wr_k_r} + 16'h0001 == wc_r) st_r <= mbs_pkg::ST_PREP;
        end
        mbs_pkg::ST_PREP: begin
          if (need_fetch) begin
            st_r <= mbs_pkg::ST_FETCH;
          end else begin
            tx_byte_r <= tx_sel;
            st_r      <= mbs_pkg::ST_SEND;
          end
        end
        mbs_pkg::ST_FETCH: begin
          word_r    <= reg_rdata_in;
          tx_byte_r <= reg_rdata_in[15:8];
          st_r      <= mbs_pkg::ST_SEND;
        end
        mbs_pkg::ST_SEND: st_r <= mbs_pkg::ST_WAIT;
        mbs_pkg::ST_WAIT: begin
          if (!tx_busy_r) begin
            tx_idx_r <= tx_idx_r + 9'h001;
            st_r     <= (tx_idx_r == body_r + 9'h001) ? mbs_pkg::ST_IDLE : mbs_pkg::ST_PREP;
          end
        end
        default: st_r <= mbs_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Register port
  logic [7:0] wr_pos;
  assign wr_pos = wb_r + {wr_k_r[6:0], 1'b0};
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      reg_addr_out  <= 16'h0000;
      reg_wdata_out <= 16'h0000;
      reg_wr_out    <= 1'b0;
      reg_rd_out    <= 1'b0;
    end else begin
      reg_wr_out <= st_r == mbs_pkg::ST_WRITE;
      reg_rd_out <= st_r == mbs_pkg::ST_PREP && need_fetch;
      if (st_r == mbs_pkg::ST_WRITE) begin
        reg_addr_out  <= ws_r + {8'h00, wr_k_r};
        reg_wdata_out <= {buf_r[wr_pos], buf_r[wr_pos + 8'h01]};
      end else if (st_r == mbs_pkg::ST_PREP) begin
        reg_addr_out <= rs_r + {8'h00, rd_off[8:1]};
      end
    end
  end

  // ==========================================================================
  // Transmitter
  logic [10:0] tx_sh_r;
  logic [15:0] tx_cnt_r;
  logic [3:0]  tx_bits_r;
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      tx_sh_r   <= 11'h7ff;
      tx_cnt_r  <= 16'h0000;
      tx_bits_r <= 4'h0;
      tx_busy_r <= 1'b0;
      tx_out    <= 1'b1;
      tx_en_out <= 1'b0;
    end else begin
      tx_out    <= tx_sh_r[0];
      tx_en_out <= st_r == mbs_pkg::ST_PREP || st_r == mbs_pkg::ST_FETCH
                   || st_r == mbs_pkg::ST_SEND || st_r == mbs_pkg::ST_WAIT;
      if (st_r == mbs_pkg::ST_SEND) begin
        tx_sh_r   <= {1'b1, ^tx_byte_r, tx_byte_r, 1'b0};
        tx_cnt_r  <= bit_cyc - 16'h0001;
        tx_bits_r <= 4'h0;
        tx_busy_r <= 1'b1;
      end else if (tx_busy_r) begin
        if (tx_cnt_r != 16'h0000) begin
          tx_cnt_r <= tx_cnt_r - 16'h0001;
        end else begin
          tx_cnt_r  <= bit_cyc - 16'h0001;
          tx_sh_r   <= {1'b1, tx_sh_r[10:1]};
          tx_bits_r <= tx_bits_r + 4'h1;
          tx_busy_r <= tx_bits_r != mbs_pkg::LAST_BIT;
        end
      end
    end
  end

  // ==========================================================================
  // Query monitoring and indication
  logic [16:0] ms_cnt_r;
  logic        ms_tick_r, flash_r;
  logic [13:0] mon_cnt_r;
  logic [7:0]  flash_cnt_r;
  always_ff @(posedge core_clk_in) begin
    if (reset_in || ms_cnt_r == 17'(MS_CYC - 1)) begin
      ms_cnt_r <= 17'h00000;
    end else begin
      ms_cnt_r <= ms_cnt_r + 17'h00001;
    end
    ms_tick_r <= !reset_in && ms_cnt_r == 17'(MS_CYC - 1);
  end

  // A zero monitoring time switches supervision off.
  always_ff @(posedge core_clk_in) begin
    if (reset_in || good_req || !bus_active_in || monitor_ms_in == 14'h0000) begin
      mon_cnt_r     <= 14'h0000;
      pump_stop_out <= 1'b0;
    end else if (mon_cnt_r == monitor_ms_in) begin
      pump_stop_out <= 1'b1;
    end else if (ms_tick_r) begin
      mon_cnt_r <= mon_cnt_r + 14'h0001;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      flash_cnt_r      <= 8'h00;
      flash_r          <= 1'b0;
      activity_led_out <= 1'b0;
      fault_led_out    <= 1'b0;
    end else begin
      if (ms_tick_r) begin
        flash_cnt_r <= (flash_cnt_r == mbs_pkg::FLASH_MS - 8'h01) ? 8'h00 : flash_cnt_r + 8'h01;
        if (flash_cnt_r == mbs_pkg::FLASH_MS - 8'h01) flash_r <= ~flash_r;
      end
      activity_led_out <= rx_busy_r | tx_busy_r;
      fault_led_out    <= (pump_stop_out | link_err_r) & flash_r;
    end
  end

endmodule // mbs_slave

// ---- tb/mbs_master.sv ----
// Master model that sends request characters on the line.
`timescale 1ns/100ps
module mbs_master (
  // Bit time in clock cycles
  input  wire logic [4:0] bit_cyc_in,
  // Line towards the slave
  output logic            line_out
);
  initial line_out = 1'b1;
  // Bytes go back to back; the idle high line afterwards is what closes the frame.
  task automatic send(input logic [7:0] q[$]);
    foreach (q[i])
      for (int k = 0; k < 11; k++) begin
        line_out = k == 0 ? 1'b0 : k < 9 ? q[i][k-1] : k == 9 ? ^q[i] : 1'b1;
        #(bit_cyc_in * 10);
      end
  endtask
endmodule // mbs_master

// ---- tb/mbs_slave_sva.sv ----
// Port timing checker of the slave telegram unit.
`timescale 1ns/100ps
module mbs_slave_sva (
  // Watched ports
  input wire logic        core_clk_in, reset_in, rx_pin_in, tx_out, tx_en_out,
  input wire logic        bus_active_in, reg_wr_out, reg_rd_out, activity_led_out,
  input wire logic        pump_stop_out,
  input wire logic [15:0] reg_addr_out,
  input wire logic [13:0] monitor_ms_in
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  // ====
  // Line and register port
  quiet_line_a: assert property (!tx_out |-> tx_en_out) else $error("line low");
  read_late_a: assert property (reg_rd_out |-> tx_en_out) else $error("early read");
  write_early_a: assert property (reg_wr_out |-> !tx_en_out) else $error("late write");
  write_step_a: assert property (reg_wr_out ##1 reg_wr_out |->
    reg_addr_out == $past(reg_addr_out) + 16'h1) else $error("write order");
  // ====
  // Indication
  rx_shown_a: assert property ($fell(rx_pin_in) && !tx_en_out |-> ##[1:6] activity_led_out)
    else $error("rx dark");
  tx_shown_a: assert property ($fell(tx_out) |-> ##[0:2] activity_led_out)
    else $error("tx dark");
  stop_idle_a: assert property (!bus_active_in |-> ##2 !pump_stop_out) else $error("stop");
  stop_off_a: assert property (monitor_ms_in == 14'h0 |-> ##2 !pump_stop_out)
    else $error("stop");
endmodule // mbs_slave_sva
bind mbs_slave mbs_slave_sva u_sva (.*);

// ---- tb/tb_top.sv ----
// Self-checking bench of the slave telegram unit.
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
  $display("unexpected %0t %h %h", $time, a, b); end end
module tb_top;
  logic        core_clk_in, reset_in, bus_active_in, tx_out, tx_en_out, reg_wr_out;
  logic        reg_rd_out, pump_stop_out, fault_led_out;
  logic [7:0]  slave_addr_in, fcs[4] = '{8'h03, 8'h06, 8'h10, 8'h17};
  logic [1:0]  baud_sel_in;
  logic [13:0] monitor_ms_in;
  logic [15:0] reg_rdata_in, reg_addr_out, reg_wdata_out;
  logic [31:0] seed = 32'h26, w, ew[$];
  wire         rx_pin_in;
  int          fails, checks_done, cyc, bc;
  mbs_slave #(.BIT_CYC_9600(24), .BIT_CYC_19200(16), .BIT_CYC_38400(8), .MS_CYC(10))
    u_dut (.*, .activity_led_out());
  mbs_master u_master (.bit_cyc_in(bc[4:0]), .line_out(rx_pin_in));
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) #1 reg_rdata_in <= ~reg_addr_out;
  always @(posedge core_clk_in) begin
    if (!reset_in && reg_wr_out !== 1'b0) begin
      `CHK(ew.size() != 0, 1'b1)
      w = ew.size() ? ew.pop_front() : 'x;
      `CHK({reg_addr_out, reg_wdata_out}, w)
    end
    if (++cyc > 100000) begin
      fails++;
      give_verdict();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c = 16'hffff;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  task automatic give_verdict();
    if (fails == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One request; the answer, or its absence, is checked byte for byte.
  task automatic xact(input logic [7:0] a, fc, input logic [15:0] st, n, input bit bad);
    logic [7:0]  q[$], e[$];
    logic [15:0] v, c;
    logic [9:0]  f;
    logic        hit;
    @(posedge core_clk_in);
    #1;
    v = xs();
    q = {a, fc, st[15:8], st[7:0], n[15:8], n[7:0]};
    e = {a, fc | 8'h80, 8'h03};
    case (fc)
      8'h03, 8'h17: begin
        if (fc == 8'h17) begin
          c = xs();
          q = {q, v[15:8], v[7:0], 8'h00, 8'h01, 8'h02, c[15:8], c[7:0]};
          ew.push_back({v, c});
        end
        if (n != 0 && n <= 16'h007d) begin
          e = {a, fc, 8'(n * 2)};
          for (int i = 0; i < n; i++) begin
            c = ~(st + 16'(i));
            e = {e, c[15:8], c[7:0]};
          end
        end
      end
      8'h06: begin
        ew.push_back({st, n});
        e = q;
      end
      8'h10: begin
        q.push_back(8'(n * 2));
        for (int i = 0; i < n; i++) begin
          c = xs();
          q = {q, c[15:8], c[7:0]};
          ew.push_back({st + 16'(i), c});
        end
        if (n != 0) e = q[0:5];
      end
      default: e = {a, fc | 8'h80, 8'h01};
    endcase
    c = crc(q);
    q = {q, c[7:0] ^ 8'(bad), c[15:8]};
    if (bad || a !== (slave_addr_in inside {[1:247]} ? slave_addr_in : 8'h14)) begin
      e.delete();
      ew.delete();
    end
    u_master.send(q);
    if (e.size() == 0) begin
      hit = 1'b0;
      repeat (bc * 60) @(posedge core_clk_in) hit |= tx_en_out;
      `CHK(hit, 1'b0)
      // Step off the clock edge so that settings changed after this task never race it.
      #1;
    end else begin
      c = crc(e);
      e = {e, c[7:0], c[15:8]};
      foreach (e[i]) begin
        for (int t = 0; t < 9999 && tx_out !== 1'b0; t++) @(posedge core_clk_in);
        #(bc * 5 + 1);
        for (int k = 0; k < 10; k++) begin
          #(bc * 10);
          f[k] = tx_out;
        end
        `CHK({f[7:0], ^f[8:0], f[9]}, {e[i], 2'b01})
      end
    end
    #(bc * 450);
    `CHK(ew.size(), 0)
  endtask
  initial begin
    logic [31:0] r;
    reset_in = 1'b1;
    bus_active_in = 1'b0;
    monitor_ms_in = 14'h0;
    slave_addr_in = 8'h00;
    baud_sel_in = 2'h1;
    bc = 16;
    repeat (4) @(posedge core_clk_in);
    #1 reset_in = 1'b0;
    #(bc * 450);
    xact(8'h14, 8'h06, 16'h0032, 16'h1234, 0);
    slave_addr_in = 8'hf7;
    xact(8'hf7, 8'h03, 16'h0010, 16'h007e, 0);
    xact(8'hf7, 8'h10, 16'h0020, 16'h0000, 0);
    xact(8'hf7, 8'h10, 16'h0030, 16'h0003, 0);
    xact(8'hf7, 8'h05, 16'h0001, 16'h0001, 0);
    xact(8'hf7, 8'h17, 16'h0040, 16'h0002, 0);
    xact(8'hf6, 8'h03, 16'h0001, 16'h0001, 0);
    xact(8'hf7, 8'h03, 16'h0001, 16'h0002, 1);
    bus_active_in = 1'b1;
    monitor_ms_in = 14'hc8;
    for (int i = 0; i < 6; i++) begin
      r = xs();
      baud_sel_in = r[1:0];
      bc = r[1:0] == 2'h0 ? 24 : r[1:0] == 2'h2 ? 8 : 16;
      slave_addr_in = 8'(r[15:8] % 247 + 1);
      xact(r[2] & r[3] ? slave_addr_in ^ 8'h01 : slave_addr_in, fcs[r[5:4]], r[31:16],
        16'(r[7:6] % 3 + 1), 0);
    end
    baud_sel_in = 2'h2;
    bc = 8;
    #30000;
    `CHK(pump_stop_out, 1'b1)
    // The fault lamp flashes, so allow one full dark half period before it must light.
    for (int t = 0; t < 2600 && fault_led_out !== 1'b1; t++) @(posedge core_clk_in);
    `CHK(fault_led_out, 1'b1)
    xact(slave_addr_in, 8'h03, 16'h0007, 16'h0001, 0);
    `CHK(pump_stop_out, 1'b0)
    `CHK(fault_led_out, 1'b0)
    give_verdict();
  end
endmodule // tb_top
